// *** logic/rmc_defines.svh ***
// Constants for the run-mode control block: timing, opcodes, register map.
// Assumes one oscillator clock and word-aligned AHB-Lite register access.
`ifndef RMC_DEFINES_SVH
`define RMC_DEFINES_SVH

`define RMC_OSC_DIV 3
`define RMC_STATES_PER_CYCLE 5
`define RMC_IDLE_OPCODE 8'h01
`define RMC_SYNC_MIN_CLKS 3'h4
`define RMC_INT_ROM_WORDS 1024

`define RMC_ADDR_CTRL 4'h0
`define RMC_ADDR_STATUS 4'h4
`define RMC_ADDR_CYCLES 4'h8

`define RMC_CTRL_CLK_OUT 0
`define RMC_CTRL_SW_STOP 1
`define RMC_CTRL_RESET 2'h0

`define RMC_ST_MODE_LO 0
`define RMC_ST_EXT_FETCH 2
`define RMC_ST_RAM_EN 3
`define RMC_ST_SYNC_CLR 4
`define RMC_ST_STEP_PIN 5

`endif

// *** logic/rmc_pkg.sv ***
// Types for the run-mode control block.
// Assumes rmc_defines.svh is on the include path.
`include "rmc_defines.svh"

package rmc_pkg;

  typedef enum logic [1:0] {RMC_RUN, RMC_STOP, RMC_IDLE} rmc_mode_t;

  typedef struct packed {
    logic [1:0] phase;
    logic [2:0] state;
  } rmc_tim_st_t;

  typedef struct packed {
    rmc_mode_t mode;
    logic ss_m1;
    logic ss_s;
    logic t0_m1;
    logic t0_s;
    logic rst_m1;
    logic rst_s;
    logic ea_m1;
    logic ea_s;
    logic hv_m1;
    logic hv_s;
    logic [2:0] t0_hi_cnt;
    logic sync_clr;
    logic idle_pend;
    logic ale;
    logic [7:0] bus_out;
    logic bus_oe_n;
    logic [3:0] p2_low;
    logic rd_n;
    logic wr_n;
    logic exp_n;
    logic pse_n;
    logic cpu_run;
    logic ram_en;
    logic ext_fetch;
    logic t0_o;
    logic t0_oe_n;
    logic clk_out_en;
    logic sw_stop;
    logic [15:0] cyc_cnt;
    logic wr_pend;
    logic [3:0] waddr;
    logic [31:0] hrdata;
  } rmc_st_t;

endpackage

// *** logic/rmc_tim_if.sv ***
// Carrier between the run-mode controller and its timing generator.
// Assumes both ends share the oscillator clock.
`timescale 1ns/1ps

interface rmc_tim_if;
  logic clr;
  logic [2:0] state;
  logic phase0;
  logic cycle_end;

  modport gen (input clr, output state, output phase0, output cycle_end);
  modport ctl (output clr, input state, input phase0, input cycle_end);
endinterface

// *** logic/rmc_timing_gen.sv ***
// Oscillator prescaler and machine-state generator.
// Assumes clr comes from logic on the same clock.
`timescale 1ns/1ps

module rmc_timing_gen
  import rmc_pkg::*;
#(
  parameter int OSC_DIV = `RMC_OSC_DIV,
  parameter int STATES = `RMC_STATES_PER_CYCLE
) (
  input wire logic hclk, // oscillator
  input wire logic hresetn, // async reset, low
  rmc_tim_if.gen tim // timing to controller
);

  localparam logic [1:0] PH_LAST = 2'(OSC_DIV - 1);
  localparam logic [2:0] ST_LAST = 3'(STATES - 1);

  rmc_tim_st_t st_ff;
  rmc_tim_st_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (tim.clr) begin
      nxt_st.phase = 2'h0;
      nxt_st.state = 3'h0;
    end else if (st_ff.phase == PH_LAST) begin
      nxt_st.phase = 2'h0;
      nxt_st.state = (st_ff.state == ST_LAST) ? 3'h0 : st_ff.state + 3'h1;
    end else begin
      nxt_st.phase = st_ff.phase + 2'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tim.state = st_ff.state;
  assign tim.phase0 = (st_ff.phase == 2'h0);
  assign tim.cycle_end = !tim.clr && st_ff.phase == PH_LAST &&
                         st_ff.state == ST_LAST;

  property p_div3;
    @(posedge hclk) disable iff (!hresetn)
      (!tim.clr && st_ff.phase == 2'h0) ##1 !tim.clr ##1 !tim.clr
      |=> st_ff.phase == 2'h0;
  endproperty
  a_div3: assert property (p_div3) else $error("state clock not osc/3");

  property p_cycle5;
    @(posedge hclk) disable iff (!hresetn)
      tim.cycle_end |=> st_ff.state == 3'h0 && st_ff.phase == 2'h0;
  endproperty
  a_cycle5: assert property (p_cycle5) else $error("cycle end off state");

endmodule

// *** logic/rmc_run_ctrl.sv ***
// Run-mode controller: single-step, idle, sync, external fetch, RAM guard.
// Assumes hclk is the oscillator; pins are asynchronous, cpu_* same clock.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/1ps

// Contract
// - Low single-step halts at the next instruction's address fetch.
// - Two-cycle instructions finish both cycles before halting.
// - Halted: strobe high, next fetch address on bus and port 2 low.
// - Single-step high releases halt; strobe falls as fetch resumes.
// - While reset is asserted, processor RAM access is blocked.
// - External-fetch high sends every program fetch to external memory.
// - Two clocks after test-0 falls the device enters state 1, phase 1; here sync_clr drops four clocks after the pin falls.
// - Idle opcode stops CPU clock; oscillator, timer, interrupts run.
// - Idle keeps all CPU registers, counters and RAM unchanged.
// - Idle holds port levels, and a statically latched bus level.
// - Idle floats a floating bus, or with external program memory.
// - Idle: strobe low, other strobes high, test-0 clock if enabled.
// - Enabled interrupt ends idle; execution resumes after the opcode.
// - Reset ends idle; five machine cycles of reset suffice.
// - State clock is the oscillator divided by three.
// - Machine cycle is five states, one address strobe per cycle.
module rmc_run_ctrl
  import rmc_pkg::*;
#(
  parameter int INT_ROM_WORDS = `RMC_INT_ROM_WORDS
) (
  input wire logic hclk, // oscillator clock
  input wire logic hresetn, // async reset, low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write access
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // always ready
  output logic hresp, // always OKAY
  output logic [31:0] hrdata, // read data
  input wire logic single_step_n, // step pin, low halts
  input wire logic sync_hv, // sync-mode level on step pin
  input wire logic test0_pin_i, // test-0 pin level
  output logic test0_pin_o, // test-0 clock out
  output logic test0_pin_oe_n, // test-0 drive, low drives
  input wire logic cpu_reset_n, // device reset pin, low
  input wire logic ext_fetch_force, // external fetch pin
  input wire logic cpu_last_cycle, // final cycle of instruction
  input wire logic cpu_opcode_valid, // opcode decoded pulse
  input wire logic [7:0] cpu_opcode, // decoded opcode
  input wire logic cpu_irq_pend, // enabled interrupt pending
  input wire logic clock_out_enable_instr, // clock-out instr pulse
  input wire logic [11:0] cpu_next_pc, // next fetch address
  input wire logic [7:0] cpu_bus_out, // CPU bus data
  input wire logic cpu_bus_oe_n, // CPU bus drive, low
  input wire logic cpu_bus_latched, // bus statically latched
  input wire logic [3:0] cpu_p2_low, // CPU port 2 low nibble
  input wire logic cpu_rd_n, // CPU read strobe
  input wire logic cpu_wr_n, // CPU write strobe
  input wire logic cpu_exp_n, // CPU expander strobe
  input wire logic cpu_pse_n, // CPU program store strobe
  output logic ale, // address latch strobe
  output logic [7:0] bus_o, // data bus out
  output logic bus_oe_n, // data bus drive, low
  output logic [3:0] p2_low_o, // port 2 low nibble
  output logic rd_n, // read strobe
  output logic wr_n, // write strobe
  output logic expander_strobe_n, // expander strobe
  output logic program_store_strobe_n, // program store strobe
  output logic cpu_clk_en, // CPU clock gate
  output logic ram_access_en, // RAM access allowed
  output logic expander_strobe_n_fetch_ext // fetch from external memory
);

  localparam logic [11:0] ROM_TOP = 12'(INT_ROM_WORDS - 1);

  rmc_st_t st_ff;
  rmc_st_t nxt_st;
  rmc_tim_if tim ();

  rmc_timing_gen u_tim (
    .hclk(hclk),
    .hresetn(hresetn),
    .tim(tim)
  );

  function automatic logic [3:0] word_addr(input logic [31:0] a);
    word_addr = {a[3:2], 2'b00};
  endfunction

  logic addr_ph;
  logic [31:0] ctrl_view;
  logic [31:0] rd_val;
  logic step_req;

  // Stopped while clear keeps the generator at S1, so a release starts clean
  assign tim.clr = st_ff.sync_clr || st_ff.mode == RMC_STOP;
  assign addr_ph = hsel && htrans[1] && hready;
  assign step_req = !st_ff.ss_s || st_ff.sw_stop;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[`RMC_CTRL_CLK_OUT] = st_ff.clk_out_en;
    ctrl_view[`RMC_CTRL_SW_STOP] = st_ff.sw_stop;
    // Bypass a pending write so back-to-back read sees it
    if (st_ff.wr_pend && st_ff.waddr == `RMC_ADDR_CTRL) begin
      ctrl_view[1:0] = hwdata[1:0];
    end
    rd_val = '0;
    case (word_addr(haddr))
      `RMC_ADDR_CTRL: rd_val = ctrl_view;
      `RMC_ADDR_STATUS: begin
        rd_val[`RMC_ST_MODE_LO +: 2] = st_ff.mode;
        rd_val[`RMC_ST_EXT_FETCH] = st_ff.ext_fetch;
        rd_val[`RMC_ST_RAM_EN] = st_ff.ram_en;
        rd_val[`RMC_ST_SYNC_CLR] = st_ff.sync_clr;
        rd_val[`RMC_ST_STEP_PIN] = st_ff.ss_s;
      end
      `RMC_ADDR_CYCLES: rd_val = {16'h0000, st_ff.cyc_cnt};
      default: rd_val = '0;
    endcase
  end

  always_comb begin
    nxt_st = st_ff;
    // Two-stage synchronisers for every pin
    nxt_st.ss_m1 = single_step_n;
    nxt_st.ss_s = st_ff.ss_m1;
    nxt_st.t0_m1 = test0_pin_i;
    nxt_st.t0_s = st_ff.t0_m1;
    nxt_st.rst_m1 = cpu_reset_n;
    nxt_st.rst_s = !st_ff.rst_m1;
    nxt_st.ea_m1 = ext_fetch_force;
    nxt_st.ea_s = st_ff.ea_m1;
    nxt_st.hv_m1 = sync_hv;
    nxt_st.hv_s = st_ff.hv_m1;

    // Bus slave: reads answered with zero wait, writes in data phase
    nxt_st.wr_pend = addr_ph && hwrite;
    nxt_st.waddr = word_addr(haddr);
    if (addr_ph && !hwrite) begin
      nxt_st.hrdata = rd_val;
    end
    if (st_ff.wr_pend && st_ff.waddr == `RMC_ADDR_CTRL) begin
      nxt_st.clk_out_en = hwdata[`RMC_CTRL_CLK_OUT];
      nxt_st.sw_stop = hwdata[`RMC_CTRL_SW_STOP];
    end
    if (clock_out_enable_instr) begin
      nxt_st.clk_out_en = 1'b1;
    end

    // Sync mode: four high clocks on test-0 clear the generators
    if (st_ff.hv_s && st_ff.t0_s) begin
      if (st_ff.t0_hi_cnt != `RMC_SYNC_MIN_CLKS) begin
        nxt_st.t0_hi_cnt = st_ff.t0_hi_cnt + 3'h1;
      end
    end else begin
      nxt_st.t0_hi_cnt = 3'h0;
    end
    if (st_ff.t0_hi_cnt == `RMC_SYNC_MIN_CLKS) begin
      nxt_st.sync_clr = 1'b1;
    end else if (!st_ff.t0_s) begin
      nxt_st.sync_clr = 1'b0;
    end

    nxt_st.ram_en = !st_ff.rst_s;
    nxt_st.ext_fetch = st_ff.ea_s || cpu_next_pc > ROM_TOP;
    if (tim.cycle_end) begin
      nxt_st.cyc_cnt = st_ff.cyc_cnt + 16'h0001;
    end
    if (cpu_opcode_valid && cpu_opcode == `RMC_IDLE_OPCODE) begin
      nxt_st.idle_pend = 1'b1;
    end

    case (st_ff.mode)
      RMC_RUN: begin
        nxt_st.cpu_run = 1'b1;
        nxt_st.ale = tim.state == 3'(`RMC_STATES_PER_CYCLE - 1);
        nxt_st.bus_out = cpu_bus_out;
        nxt_st.bus_oe_n = cpu_bus_oe_n;
        nxt_st.p2_low = cpu_p2_low;
        nxt_st.rd_n = cpu_rd_n;
        nxt_st.wr_n = cpu_wr_n;
        nxt_st.exp_n = cpu_exp_n;
        nxt_st.pse_n = cpu_pse_n;
        // Step pin looked at only at cycle ends, on instruction bounds
        if (tim.cycle_end && cpu_last_cycle && !st_ff.rst_s) begin
          if (st_ff.idle_pend) begin
            nxt_st.mode = RMC_IDLE;
            nxt_st.idle_pend = 1'b0;
            nxt_st.cpu_run = 1'b0;
            nxt_st.ale = 1'b0;
            nxt_st.rd_n = 1'b1;
            nxt_st.wr_n = 1'b1;
            nxt_st.exp_n = 1'b1;
            nxt_st.pse_n = 1'b1;
            nxt_st.bus_out = st_ff.bus_out;
            nxt_st.p2_low = st_ff.p2_low;
            nxt_st.bus_oe_n = st_ff.bus_oe_n || !cpu_bus_latched ||
                              st_ff.ext_fetch;
          end else if (step_req) begin
            nxt_st.mode = RMC_STOP;
            nxt_st.cpu_run = 1'b0;
            nxt_st.ale = 1'b1;
            nxt_st.bus_out = cpu_next_pc[7:0];
            nxt_st.bus_oe_n = 1'b0;
            nxt_st.p2_low = cpu_next_pc[11:8];
          end
        end
      end
      RMC_STOP: begin
        // Bus lost to the address while stopped; latch it outside if needed
        if (!step_req || st_ff.rst_s) begin
          nxt_st.mode = RMC_RUN;
          nxt_st.ale = 1'b0;
          nxt_st.cpu_run = 1'b1;
          nxt_st.bus_oe_n = 1'b1;
        end
      end
      RMC_IDLE: begin
        if (st_ff.rst_s) begin
          nxt_st.mode = RMC_RUN;
          nxt_st.cpu_run = 1'b1;
        end else if (tim.cycle_end && cpu_irq_pend) begin
          nxt_st.mode = RMC_RUN;
          nxt_st.cpu_run = 1'b1;
        end
      end
      default: nxt_st.mode = RMC_RUN;
    endcase

    if (st_ff.rst_s) begin
      nxt_st.clk_out_en = 1'b0;
      nxt_st.idle_pend = 1'b0;
    end
    nxt_st.t0_oe_n = !st_ff.clk_out_en;
    nxt_st.t0_o = st_ff.clk_out_en && tim.phase0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff <= '0;
      st_ff.mode <= RMC_RUN;
      st_ff.ss_m1 <= 1'b1;
      st_ff.ss_s <= 1'b1;
      st_ff.rst_m1 <= 1'b1;
      st_ff.bus_oe_n <= 1'b1;
      st_ff.rd_n <= 1'b1;
      st_ff.wr_n <= 1'b1;
      st_ff.exp_n <= 1'b1;
      st_ff.pse_n <= 1'b1;
      st_ff.t0_oe_n <= 1'b1;
      st_ff.cpu_run <= 1'b1;
      st_ff.ram_en <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  assign hrdata = st_ff.hrdata;
  assign test0_pin_o = st_ff.t0_o;
  assign test0_pin_oe_n = st_ff.t0_oe_n;
  assign ale = st_ff.ale;
  assign bus_o = st_ff.bus_out;
  assign bus_oe_n = st_ff.bus_oe_n;
  assign p2_low_o = st_ff.p2_low;
  assign rd_n = st_ff.rd_n;
  assign wr_n = st_ff.wr_n;
  assign expander_strobe_n = st_ff.exp_n;
  assign program_store_strobe_n = st_ff.pse_n;
  assign cpu_clk_en = st_ff.cpu_run;
  assign ram_access_en = st_ff.ram_en;
  assign expander_strobe_n_fetch_ext = st_ff.ext_fetch;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_stop_entry;
    st_ff.mode == RMC_RUN && tim.cycle_end && cpu_last_cycle &&
      !st_ff.ss_s && !st_ff.rst_s && !st_ff.idle_pend
      |=> st_ff.mode == RMC_STOP;
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("no halt");

  property p_stop_bound;
    $rose(st_ff.mode == RMC_STOP) |-> $past(cpu_last_cycle);
  endproperty
  a_stop_bound: assert property (p_stop_bound) else $error("mid halt");

  property p_stop_addr;
    st_ff.mode == RMC_STOP |-> ale && !bus_oe_n &&
      ($rose(st_ff.mode == RMC_STOP) || $stable(bus_o));
  endproperty
  a_stop_addr: assert property (p_stop_addr) else $error("bad halt");

  property p_release;
    st_ff.mode == RMC_STOP && st_ff.ss_s && !st_ff.sw_stop
      |=> !ale && cpu_clk_en ##1 !ale;
  endproperty
  a_release: assert property (p_release) else $error("no release");

  property p_ram_block;
    st_ff.rst_s |=> !ram_access_en;
  endproperty
  a_ram_block: assert property (p_ram_block) else $error("RAM open");

  property p_ext_fetch;
    st_ff.ea_s |=> expander_strobe_n_fetch_ext;
  endproperty
  a_ext_fetch: assert property (p_ext_fetch) else $error("int fetch");

  property p_sync_start;
    $fell(st_ff.sync_clr) |-> tim.state == 3'h0 && tim.phase0;
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("sync off");

  property p_idle_frozen;
    st_ff.mode == RMC_IDLE |-> !cpu_clk_en && !ale && rd_n && wr_n &&
      expander_strobe_n && program_store_strobe_n;
  endproperty
  a_idle_frozen: assert property (p_idle_frozen) else $error("idle run");

  property p_idle_hold;
    st_ff.mode == RMC_IDLE ##1 st_ff.mode == RMC_IDLE
      |-> $stable(bus_o) && $stable(bus_oe_n) && $stable(p2_low_o);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("idle moved");

  property p_idle_exit;
    st_ff.mode == RMC_IDLE && (st_ff.rst_s || tim.cycle_end && cpu_irq_pend)
      |=> st_ff.mode == RMC_RUN && cpu_clk_en;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle stuck");

  c_stop: cover property ($rose(st_ff.mode == RMC_STOP));
  c_idle: cover property ($rose(st_ff.mode == RMC_IDLE));
  c_sync: cover property ($fell(st_ff.sync_clr));

endmodule

// *** dv/rmc_step_partner.sv ***
// Stepping flip-flop model that drives the single-step pin.
// Assumes ale from the device and step requests from the bench.
`timescale 1ns/1ps

module rmc_step_partner (
  input wire logic hclk, // bench clock
  input wire logic ale, // address latch strobe
  input wire logic preset_run, // high keeps free run
  input wire logic step_req, // clocks a one in
  output logic single_step_n // step pin, low halts
);
  logic q_ff = 1'b0;

  // Low strobe clears; a clocked one is held until the strobe falls
  always @(posedge hclk or negedge ale) begin
    if (!ale) begin
      q_ff <= 1'b0;
    end else if (step_req) begin
      q_ff <= 1'b1;
    end
  end

  // Preset beats clear, so the step pin never requests a halt in run mode
  assign single_step_n = preset_run | (ale & q_ff);
endmodule

// *** dv/test_cpu_run_mode_control.sv ***
// Self-checking bench for the run-mode controller.
// Assumes the stepping partner model and the design files are compiled.
`timescale 1ns/1ps
`include "rmc_defines.svh"

module test_cpu_run_mode_control;
  localparam logic [31:0] A_CT = {28'h0, `RMC_ADDR_CTRL};
  localparam logic [31:0] A_ST = {28'h0, `RMC_ADDR_STATUS};
  localparam logic [31:0] A_CY = {28'h0, `RMC_ADDR_CYCLES};
  // Inside the internal program space, so only the pin forces external
  localparam logic [11:0] PC = 12'h35C;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic hready;
  wire logic last_cyc;
  logic hreadyout, hresp, ale, bus_oe_n, rd_n, wr_n, exp_n, pse_n;
  logic [7:0] bus_o;
  logic [3:0] p2_low_o;
  logic t0_o, t0_oe_n, cpu_clk_en, ram_access_en, expander_strobe_n_fetch_ext;
  logic single_step_n, preset_run = 1'b1, step_req = 1'b0;
  logic sync_hv = 1'b0, test0_in = 1'b0, cpu_reset_n = 1'b1;
  logic ext_in = 1'b0, two_cyc = 1'b0, half = 1'b1, ale_q = 1'b0;
  logic op_v = 1'b0, irq = 1'b0, clk_out_i = 1'b0, cstb_n = 1'b1;
  logic [7:0] opcode = 8'h00, cbus = 8'h3C;
  logic [3:0] cp2 = 4'h6;
  int n_fail = 0, checks_done = 0;
  int n;

  assign hready = hreadyout;
  // Two-cycle instructions end on every second machine cycle
  assign last_cyc = ~two_cyc | half;

  initial begin
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    ale_q <= ale;
    if (ale_q === 1'b1 && ale === 1'b0) begin
      half <= ~half;
    end
  end

  rmc_step_partner ss_u (.hclk(hclk), .ale(ale), .preset_run(preset_run),
    .step_req(step_req), .single_step_n(single_step_n));

  rmc_run_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .single_step_n(single_step_n),
    .sync_hv(sync_hv), .test0_pin_i(test0_in), .test0_pin_o(t0_o),
    .test0_pin_oe_n(t0_oe_n), .cpu_reset_n(cpu_reset_n),
    .ext_fetch_force(ext_in), .cpu_last_cycle(last_cyc),
    .cpu_opcode_valid(op_v), .cpu_opcode(opcode), .cpu_irq_pend(irq),
    .clock_out_enable_instr(clk_out_i), .cpu_next_pc(PC),
    .cpu_bus_out(cbus), .cpu_bus_oe_n(1'b0), .cpu_bus_latched(1'b1),
    .cpu_p2_low(cp2), .cpu_rd_n(cstb_n), .cpu_wr_n(cstb_n),
    .cpu_exp_n(cstb_n), .cpu_pse_n(cstb_n), .ale(ale), .bus_o(bus_o),
    .bus_oe_n(bus_oe_n), .p2_low_o(p2_low_o), .rd_n(rd_n), .wr_n(wr_n),
    .expander_strobe_n(exp_n), .program_store_strobe_n(pse_n),
    .cpu_clk_en(cpu_clk_en), .ram_access_en(ram_access_en),
    .expander_strobe_n_fetch_ext(expander_strobe_n_fetch_ext));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  function automatic logic sigv(input int s);
    case (s)
      0: return ale;
      1: return cpu_clk_en;
      2: return ram_access_en;
      3: return expander_strobe_n_fetch_ext;
      default: return t0_o;
    endcase
  endfunction

  // Bounded wait for a selected output to reach a level
  task automatic wt(input int s, input logic v);
    int i;
    i = 0;
    while (sigv(s) !== v) begin
      @(posedge hclk);
      i++;
      if (i > 400) begin
        n_fail++;
        test_done;
      end
    end
  endtask

  task automatic run_len(input int s, input logic v, output int k);
    k = 0;
    while (sigv(s) === v && k < 100) begin
      @(posedge hclk);
      k++;
    end
  endtask

  task automatic hwait;
    int i;
    i = 0;
    do begin
      @(posedge hclk);
      i++;
    end while (hready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail++;
      test_done;
    end
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hwait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait;
    r = hrdata;
    chk(hresp, 1'b0);
  endtask

  // Release a halt and count strobe pulses until the next halt
  task automatic step(input logic two, input int exp);
    int i;
    int rises;
    logic prev;
    rises = 0;
    i = 0;
    two_cyc <= two;
    half <= 1'b1;
    step_req <= 1'b1;
    @(posedge hclk);
    step_req <= 1'b0;
    wt(1, 1'b1);
    chk(ale, 1'b0);
    prev = ale;
    while (cpu_clk_en !== 1'b0 && i < 400) begin
      @(posedge hclk);
      i++;
      if (ale === 1'b1 && prev === 1'b0) begin
        rises++;
      end
      prev = ale;
    end
    chk(cpu_clk_en, 1'b0);
    chk(rises, exp);
    chk(ale, 1'b1);
  endtask

  task automatic idle_op;
    op_v <= 1'b1;
    opcode <= `RMC_IDLE_OPCODE;
    @(posedge hclk);
    op_v <= 1'b0;
    wt(1, 1'b0);
    repeat (2) @(posedge hclk);
  endtask

  initial begin
    repeat (90000) @(posedge hclk);
    n_fail++;
    test_done;
  end

  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, A_CT, 32'h0);
    chk(r, 32'h0);
    ahb(1'b0, A_ST, 32'h0);
    chk(r, 32'h28);
    ahb(1'b0, 32'h0000000C, 32'h0);
    chk(r, 32'h0);
    chk({t0_oe_n, rd_n, wr_n, exp_n, pse_n}, 5'h1F);
    wt(0, 1'b1);
    run_len(0, 1'b1, n);
    chk(n, 3);
    run_len(0, 1'b0, n);
    chk(n, 12);
    ahb(1'b0, A_CY, 32'h0);
    n = r;
    repeat (28) @(posedge hclk);
    ahb(1'b0, A_CY, 32'h0);
    chk(r - n, 2);
    sync_hv <= 1'b1;
    repeat (5) @(posedge hclk);
    test0_in <= 1'b1;
    repeat (8) @(posedge hclk);
    ahb(1'b0, A_ST, 32'h0);
    chk(r[4], 1'b1);
    test0_in <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (ale !== 1'b1 && n < 60);
    chk(n, 18);
    repeat (4) @(posedge hclk);
    sync_hv <= 1'b0;
    ahb(1'b1, A_CT, 32'h1);
    ahb(1'b0, A_CT, 32'h0);
    chk(r, 32'h1);
    chk(t0_oe_n, 1'b0);
    wt(4, 1'b1);
    run_len(4, 1'b1, n);
    chk(n, 1);
    run_len(4, 1'b0, n);
    chk(n, 2);
    ahb(1'b1, A_CT, 32'h0);
    clk_out_i <= 1'b1;
    @(posedge hclk);
    clk_out_i <= 1'b0;
    idle_op;
    cstb_n <= 1'b0;
    cbus <= 8'hC3;
    cp2 <= 4'h9;
    repeat (3) @(posedge hclk);
    chk({ale, rd_n, wr_n, exp_n, pse_n}, 5'h0F);
    chk({bus_oe_n, bus_o, p2_low_o}, 13'h03C6);
    ahb(1'b0, A_ST, 32'h0);
    chk(r[1:0], 2'h2);
    chk(cpu_clk_en, 1'b0);
    chk(t0_oe_n, 1'b0);
    wt(4, 1'b1);
    run_len(4, 1'b1, n);
    chk(n, 1);
    irq <= 1'b1;
    wt(1, 1'b1);
    irq <= 1'b0;
    cstb_n <= 1'b1;
    cbus <= 8'h3C;
    cp2 <= 4'h6;
    preset_run <= 1'b0;
    wt(1, 1'b0);
    chk({ale, bus_oe_n, bus_o, p2_low_o}, {2'b10, PC[7:0], PC[11:8]});
    ahb(1'b0, A_ST, 32'h0);
    chk(r[1:0], 2'h1);
    repeat (60) @(posedge hclk);
    chk({ale, cpu_clk_en}, 2'h2);
    step(1'b0, 1);
    step(1'b1, 2);
    preset_run <= 1'b1;
    wt(1, 1'b1);
    run_len(1, 1'b1, n);
    chk(n, 100);
    // Software stop acts like the step pin held low
    ahb(1'b1, A_CT, 32'h2);
    wt(1, 1'b0);
    chk(ale, 1'b1);
    ahb(1'b1, A_CT, 32'h0);
    wt(1, 1'b1);
    cpu_reset_n <= 1'b0;
    @(posedge hclk);
    ext_in <= 1'b1;
    wt(2, 1'b0);
    wt(3, 1'b1);
    chk(t0_oe_n, 1'b1);
    repeat (75) @(posedge hclk);
    cpu_reset_n <= 1'b1;
    wt(2, 1'b1);
    ahb(1'b0, A_ST, 32'h0);
    chk(r[3:2], 2'h3);
    idle_op;
    chk(bus_oe_n, 1'b1);
    cpu_reset_n <= 1'b0;
    wt(1, 1'b1);
    repeat (75) @(posedge hclk);
    cpu_reset_n <= 1'b1;
    repeat (5) @(posedge hclk);
    test_done;
  end
endmodule
